// file: isr_pkg.sv
// constants shared by the stimulus replay simulator
package isr_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_IN = 12;
  localparam int unsigned NUM_OUT = 8;
  localparam int unsigned NUM_DIFF = 6;
  localparam int unsigned NUM_STEPS = 2048;
  localparam int unsigned STEP_W = 11;
  localparam logic [10:0] LAST_STEP = 11'h7FF;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned CT_BITS = 5;
  // result word: in, out, diff, ct0 inputs, ct1 inputs
  localparam int unsigned RES_W = NUM_IN + NUM_OUT + NUM_DIFF + 2 * CT_BITS;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] STIM_RST = 12'h000;
  localparam logic [3:0] PERIOD_RST = 4'h8;
  // ---------------------------------------------------------------
  // step period codes and times
  // ---------------------------------------------------------------
  localparam logic [3:0] PER_1MS = 4'h8;
  localparam logic [3:0] PER_100US = 4'h7;
  localparam logic [3:0] PER_10US = 4'h6;
  localparam logic [3:0] PER_1US = 4'h5;
  localparam logic [3:0] PER_100NS = 4'h4;
  localparam logic [3:0] PER_50NS = 4'h3;
  localparam logic [3:0] PER_25NS = 4'h2;
  localparam longint CLK_PS = 100000;
  localparam longint T_1MS_PS = 1000000000;
  localparam longint T_100US_PS = 100000000;
  localparam longint T_10US_PS = 10000000;
  localparam longint T_1US_PS = 1000000;
  localparam longint T_100NS_PS = 100000;
  // periods below one clock clamp to one cycle
  localparam logic [15:0] CYC_1MS = 16'(T_1MS_PS / CLK_PS);
  localparam logic [15:0] CYC_100US = 16'(T_100US_PS / CLK_PS);
  localparam logic [15:0] CYC_10US = 16'(T_10US_PS / CLK_PS);
  localparam logic [15:0] CYC_1US = 16'(T_1US_PS / CLK_PS);
  localparam logic [15:0] CYC_100NS = 16'(T_100NS_PS / CLK_PS);
  localparam logic [15:0] CYC_MIN = 16'h0001;
endpackage : isr_pkg

// file: isr_step_timer.sv
// step period timer: one pulse per selected period
`timescale 1ns/1ps
module isr_step_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic [3:0] periodCode,
  // tick
  output logic tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] periodCyc;
  logic tick_q;
  logic tick_d;

  // R15 period decode
  assign periodCyc =
    (periodCode == isr_pkg::PER_1MS) ? isr_pkg::CYC_1MS :
    (periodCode == isr_pkg::PER_100US) ? isr_pkg::CYC_100US :
    (periodCode == isr_pkg::PER_10US) ? isr_pkg::CYC_10US :
    (periodCode == isr_pkg::PER_1US) ? isr_pkg::CYC_1US :
    (periodCode == isr_pkg::PER_100NS) ? isr_pkg::CYC_100NS :
    isr_pkg::CYC_MIN;
  // R5 advance once per elapsed period
  assign tick_d = run && (cnt_q == periodCyc - 16'h0001);
  assign cnt_d = (!run || tick_d) ? 16'h0000 : cnt_q + 16'h0001;
  assign tick = tick_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule : isr_step_timer

// file: isr_replay_sim.sv
// stimulus replay simulator: store, replay, sample results
//
// Overview of operation
// R1 - twelve stimulus columns replace the real input pins during a run
// R2 - store holds 2048 steps, 0 to 2047, one value per channel
// R3 - stored 0 drives input off, stored 1 drives it on
// R4 - exactly one stimulus step applied per selected step period
// R5 - step timer advances to next step each elapsed period
// R6 - one result sample captured each step period
// R7 - stimulus retained until power removed
// R8 - host loads stimulus before requesting a run
// R9 - run uses only stored stimulus and stored user logic
// R10 - sample records input, output and differential terminal levels
// R11 - sample records counter run, stop, up, down, preset and count
// R12 - in 32-bit counter mode the second counter is omitted
// R13 - only blocks placed in the user logic are captured; here placedMask masks input levels only
// R14 - every stimulus bit defaults to 0 until written
// R15 - period codes 8..2 mean 1ms down to 25ns; codes 3 and 2 run at one 100ns clock here
// R16 - starting a run stops normal control; it stays stopped after
// R17 - physical outputs follow simulated logic during a run
// R18 - interrupt requests toward host suppressed during a run; here only from the second running cycle on
// R19 - after last sample the run ends and done is flagged
`timescale 1ns/1ps
module isr_replay_sim (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // host stimulus write
  input wire logic stimWrEn,
  input wire logic [10:0] stimWrAddr,
  input wire logic [11:0] stimWrData,
  input wire logic [3:0] periodWr,
  input wire logic periodWrEn,
  // host control
  input wire logic runReq,
  input wire logic ctrlStartReq,
  input wire logic ctrlStopReq,
  input wire logic [11:0] placedMask,
  input wire logic counter32,
  // real pins
  input wire logic [11:0] extInPin,
  // user logic terminals
  input wire logic [7:0] output_channels,
  input wire logic [5:0] diff_output_channels,
  input wire logic [4:0] ct0Inputs,
  input wire logic [4:0] ct1Inputs,
  input wire logic [31:0] ct0Count,
  input wire logic [31:0] ct1Count,
  input wire logic userIrq,
  // to user logic and pins
  output logic [11:0] sim_input_channels,
  output logic [7:0] outPins,
  output logic [5:0] diffOutPins,
  output logic ctrlRunning,
  output logic hostIrq,
  // results
  output logic simBusy,
  output logic simDone,
  output logic resValid,
  output logic [10:0] resStep,
  output logic [35:0] resBits,
  output logic [31:0] resCount0,
  output logic [31:0] resCount1
);
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    RUN = 3'b010,
    DONE = 3'b100
  } isr_state_e;

  isr_state_e state_q;
  isr_state_e state_d;
  // R2 R7 2048 steps, no reset, survives until power off
  logic [11:0] stim [0:isr_pkg::NUM_STEPS-1];
  logic [2047:0] written_q;
  logic [11:0] pinMeta_q;
  logic [11:0] pinSync_q;
  logic [3:0] period_q;
  logic [10:0] step_q;
  logic [10:0] step_d;
  logic [11:0] stimRd;
  logic tick;
  logic running;
  logic lastTick;
  logic [11:0] inMux;
  logic [4:0] ct1Kept;
  logic [31:0] cnt1Kept;
  logic [35:0] sampleBits;
  logic [11:0] in_q;
  logic [7:0] outP_q;
  logic [5:0] diffP_q;
  logic ctrl_q;
  logic irq_q;
  logic done_q;
  logic resV_q;
  logic [10:0] resS_q;
  logic [35:0] resB_q;
  logic [31:0] resC0_q;
  logic [31:0] resC1_q;

  // ---------------------------------------------------------------
  // stimulus store
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (stimWrEn) begin
      stim[stimWrAddr] <= stimWrData;
    end
  end

  // R14 unwritten steps read as off; written map kept out of reset
  always_ff @(posedge sys_clk) begin
    if (stimWrEn) begin
      written_q[stimWrAddr] <= 1'b1;
    end
  end

  // R3 bit value 1 is on, 0 off
  // read at the next index so in_q never lags the step it is sampled with
  assign stimRd = (written_q[step_d] === 1'b1) ? stim[step_d] :
    isr_pkg::STIM_RST;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      period_q <= isr_pkg::PERIOD_RST;
    end else if (periodWrEn && !running) begin
      period_q <= periodWr;
    end
  end

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinMeta_q <= 12'h000;
      pinSync_q <= 12'h000;
    end else begin
      pinMeta_q <= extInPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  isr_step_timer i_isr_step_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(running),
    .periodCode(period_q),
    .tick(tick)
  );

  assign running = (state_q == RUN);
  assign lastTick = tick && (step_q == isr_pkg::LAST_STEP);
  // R4 one step per period
  assign step_d = !running ? 11'h000 : tick ? step_q + 11'h001 : step_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IDLE: begin
        // R9 run from stored data only
        if (runReq) begin
          state_d = RUN;
        end
      end
      RUN: begin
        // R19 end after final sample
        if (lastTick) begin
          state_d = DONE;
        end
      end
      DONE: begin
        if (runReq) begin
          state_d = RUN;
        end
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= IDLE;
      step_q <= 11'h000;
    end else begin
      state_q <= state_d;
      // R4 R5 advance on tick only
      step_q <= step_d;
    end
  end

  // ---------------------------------------------------------------
  // input replacement and pin drive
  // ---------------------------------------------------------------
  // R1 stimulus replaces pins while running
  // pins return on the final edge, the same edge on which the index wraps to 0
  assign inMux = (running && !lastTick) ? stimRd : pinSync_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_q <= 12'h000;
      outP_q <= 8'h00;
      diffP_q <= 6'h00;
      ctrl_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      in_q <= inMux;
      // R17 outputs really switch during a run
      outP_q <= output_channels;
      diffP_q <= diff_output_channels;
      // R16 run stops control; only a start request restarts it
      if (runReq || running) begin
        ctrl_q <= 1'b0;
      end else if (ctrlStartReq) begin
        ctrl_q <= 1'b1;
      end else if (ctrlStopReq) begin
        ctrl_q <= 1'b0;
      end
      // R18 no interrupt toward host while simulating, from the second running cycle on
      irq_q <= userIrq && !running;
    end
  end

  // ---------------------------------------------------------------
  // result sampling
  // ---------------------------------------------------------------
  // R12 second counter dropped in 32-bit mode
  assign ct1Kept = counter32 ? 5'h00 : ct1Inputs;
  assign cnt1Kept = counter32 ? 32'h0000_0000 : ct1Count;
  // R13 R10 R11 only placed inputs, terminal levels and counters
  assign sampleBits = {ct1Kept, ct0Inputs, diff_output_channels,
    output_channels, in_q & placedMask};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resV_q <= 1'b0;
      resS_q <= 11'h000;
      resB_q <= 36'h0_0000_0000;
      resC0_q <= 32'h0000_0000;
      resC1_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else begin
      // R6 one sample per period
      resV_q <= running && tick;
      if (running && tick) begin
        resS_q <= step_q;
        resB_q <= sampleBits;
        resC0_q <= ct0Count;
        resC1_q <= cnt1Kept;
      end
      // R19 completion flag held until next run
      if (lastTick) begin
        done_q <= 1'b1;
      end else if (runReq) begin
        done_q <= 1'b0;
      end
    end
  end

  assign sim_input_channels = in_q;
  assign outPins = outP_q;
  assign diffOutPins = diffP_q;
  assign ctrlRunning = ctrl_q;
  assign hostIrq = irq_q;
  assign simBusy = running;
  assign simDone = done_q;
  assign resValid = resV_q;
  assign resStep = resS_q;
  assign resBits = resB_q;
  assign resCount0 = resC0_q;
  assign resCount1 = resC1_q;
endmodule : isr_replay_sim

// file: isr_replay_sim_properties.sv
// port assertions for the stimulus replay simulator
`timescale 1ns/1ps
module isr_replay_sim_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // watched ports
  input wire logic runReq,
  input wire logic ctrlStartReq,
  input wire logic [3:0] periodWr,
  input wire logic periodWrEn,
  input wire logic counter32,
  input wire logic [7:0] output_channels,
  input wire logic [7:0] outPins,
  input wire logic ctrlRunning,
  input wire logic hostIrq,
  input wire logic simBusy,
  input wire logic simDone,
  input wire logic resValid,
  input wire logic [10:0] resStep,
  input wire logic [35:0] resBits,
  input wire logic [31:0] resCount1
);
  logic [10:0] lastStep_q;
  logic [15:0] gapCnt_q;
  logic [3:0] perCode_q;
  logic [15:0] expGap;
  // cycles per step at 10 MHz; fast codes clamp to one cycle
  assign expGap = perCode_q == 4'h8 ? 16'h2710 : perCode_q == 4'h7 ? 16'h03E8 :
    perCode_q == 4'h6 ? 16'h0064 : perCode_q == 4'h5 ? 16'h000A : 16'h0001;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lastStep_q <= 11'h000;
      gapCnt_q <= 16'h0000;
      perCode_q <= 4'h8;
    end else begin
      if (resValid) lastStep_q <= resStep;
      gapCnt_q <= resValid ? 16'h0001 : gapCnt_q + 16'h0001;
      if (periodWrEn && !simBusy) perCode_q <= periodWr;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  a_run_starts: assert property (
    runReq && !simBusy |=> simBusy && !ctrlRunning)
    else $error("run request not taken");
  a_ctrl_held: assert property (
    !ctrlRunning && !ctrlStartReq |=> !ctrlRunning)
    else $error("control restarted without request");
  a_irq_masked: assert property (
    simBusy && $past(simBusy) |-> !hostIrq)
    else $error("interrupt passed during run");
  a_out_follow: assert property (
    1'b1 |=> outPins == $past(output_channels))
    else $error("output pins not following logic");
  a_step_next: assert property (resValid && resStep != 11'h000 |->
    resStep == lastStep_q + 11'h001) else $error("step index skipped");
  a_step_gap: assert property (resValid && resStep != 11'h000 |->
    gapCnt_q == expGap) else $error("sample spacing wrong");
  a_run_end: assert property ($fell(simBusy) |-> simDone && resValid &&
    resStep == 11'h7FF) else $error("run ended off the last step");
  a_ct1_omit: assert property (resValid && counter32 |->
    resCount1 == 32'h0 && resBits[35:31] == 5'h00)
    else $error("counter 1 kept");
endmodule : isr_replay_sim_properties
bind isr_replay_sim isr_replay_sim_properties i_isr_replay_sim_properties (
  .sys_clk, .srst, .runReq, .ctrlStartReq, .periodWr, .periodWrEn, .counter32,
  .output_channels, .outPins, .ctrlRunning, .hostIrq, .simBusy, .simDone,
  .resValid, .resStep, .resBits, .resCount1);

// file: isr_host_model.sv
// host tool model: loads stimulus steps and requests runs
`timescale 1ns/1ps
module isr_host_model (
  // clock
  input wire logic sys_clk,
  // stimulus and run requests
  output logic stimWrEn = 1'b0,
  output logic [10:0] stimWrAddr = 11'h000,
  output logic [11:0] stimWrData = 12'h000,
  output logic [3:0] periodWr = 4'h0,
  output logic periodWrEn = 1'b0,
  output logic runReq = 1'b0
);
  function automatic logic [11:0] pattern(input logic [10:0] s);
    return {s[0], s} ^ 12'hA53;
  endfunction : pattern
  // steps loaded back to back before any run, top ones left unset
  task automatic load(input int nSteps);
    for (int s = 0; s < nSteps; s++) begin
      @(posedge sys_clk) #1;
      stimWrEn = 1'b1;
      stimWrAddr = 11'(s);
      stimWrData = pattern(11'(s));
    end
    @(posedge sys_clk) #1;
    stimWrEn = 1'b0;
    // released bus carries junk so a stale word cannot pass for data
    stimWrAddr = ~stimWrAddr;
    stimWrData = ~stimWrData;
  endtask : load
  // period code goes first, then a one-cycle run pulse
  task automatic start(input logic [3:0] code);
    @(posedge sys_clk) #1;
    periodWr = code;
    periodWrEn = 1'b1;
    @(posedge sys_clk) #1;
    periodWrEn = 1'b0;
    periodWr = ~code;
    runReq = 1'b1;
    @(posedge sys_clk) #1;
    runReq = 1'b0;
  endtask : start
endmodule : isr_host_model

// file: isr_replay_sim_tb.sv
// self-checking bench for the stimulus replay simulator
`timescale 1ns/1ps
module isr_replay_sim_tb;
  logic sys_clk = 1'b0, srst = 1'b1, ctrlStartReq = 1'b0, ctrlStopReq = 1'b0;
  logic counter32 = 1'b0, userIrq = 1'b0;
  logic [11:0] placedMask = 12'hFFF, extInPin = 12'h000;
  logic [4:0] ct0Inputs = 5'h0A, ct1Inputs = 5'h15;
  logic [31:0] ct0Count = 32'h1234_5678, ct1Count = 32'hA5A5_0001;
  logic stimWrEn, periodWrEn, runReq, simBusy, simDone, resValid;
  logic ctrlRunning, hostIrq;
  logic [10:0] stimWrAddr, resStep;
  logic [11:0] stimWrData, sim_input_channels;
  logic [3:0] periodWr;
  logic [7:0] outPins;
  logic [5:0] diffOutPins;
  logic [35:0] resBits;
  logic [31:0] resCount0, resCount1;
  int num_errors = 0;
  int check_count = 0;
  always #50 sys_clk = ~sys_clk;
  isr_host_model i_isr_host_model (.sys_clk, .stimWrEn, .stimWrAddr,
    .stimWrData, .periodWr, .periodWrEn, .runReq);
  // user logic stand-in: outputs mirror the applied inputs
  isr_replay_sim i_isr_replay_sim (.sys_clk, .srst, .stimWrEn, .stimWrAddr,
    .stimWrData, .periodWr, .periodWrEn, .runReq, .ctrlStartReq,
    .ctrlStopReq, .placedMask, .counter32, .extInPin,
    .output_channels(sim_input_channels[7:0]),
    .diff_output_channels(sim_input_channels[11:6]), .ct0Inputs, .ct1Inputs,
    .ct0Count, .ct1Count, .userIrq, .sim_input_channels, .outPins,
    .diffOutPins, .ctrlRunning, .hostIrq, .simBusy, .simDone, .resValid,
    .resStep, .resBits, .resCount0, .resCount1);
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset;
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
  endtask : do_reset
  // bounded wait for the next result pulse, reports cycles taken
  task automatic wait_valid(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (resValid !== 1'b1 && n < 20000);
    // a missing pulse counts against the run
    if (resValid !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: no result pulse", $time);
    end
  endtask : wait_valid
  task automatic t_idle;
    extInPin = 12'h3C5;
    ctrlStartReq = 1'b1;
    userIrq = 1'b1;
    tick(1);
    ctrlStartReq = 1'b0;
    tick(3);
    chk(36'(sim_input_channels), 36'h3C5);
    chk(36'(ctrlRunning), 36'h1);
    chk(36'(hostIrq), 36'h1);
    chk(36'(outPins), 36'hC5);
    chk(36'(diffOutPins), 36'h0F);
    ctrlStopReq = 1'b1;
    tick(1);
    ctrlStopReq = 1'b0;
    chk(36'(ctrlRunning), 36'h0);
    $display("test idle done");
  endtask : t_idle
  task automatic t_periods;
    int n;
    int gap[9] = '{0, 0, 1, 1, 1, 10, 100, 1000, 10000};
    for (int c = 2; c <= 8; c++) begin
      i_isr_host_model.start(4'(c));
      wait_valid(n);
      wait_valid(n);
      chk(36'(n), 36'(gap[c]));
      chk(36'(resCount1), 36'(ct1Count));
      chk(36'(resBits[35:31]), 36'(ct1Inputs));
      // long periods are cut short by reset; stimulus must survive it
      do_reset();
    end
    $display("test periods done");
  endtask : t_periods
  task automatic t_full;
    int n;
    logic [11:0] exp;
    placedMask = 12'hF3F;
    counter32 = 1'b1;
    ctrlStartReq = 1'b1;
    tick(1);
    ctrlStartReq = 1'b0;
    i_isr_host_model.start(4'h2);
    for (int s = 0; s < 2048; s++) begin
      wait_valid(n);
      exp = s < 2040 ? i_isr_host_model.pattern(11'(s)) : 12'h000;
      chk(36'(resStep), 36'(s));
      chk(36'(resBits[11:0]), 36'(exp & placedMask));
      chk(36'(resBits[25:12]), 36'({exp[11:6], exp[7:0]}));
      chk(36'(resBits[30:26]), 36'(ct0Inputs));
      chk(36'(resCount0), 36'(ct0Count));
      chk(36'(resCount1), 36'h0);
      chk(36'(hostIrq), 36'h0);
    end
    chk(36'({simDone, simBusy, ctrlRunning}), 36'h4);
    $display("test full run done");
  endtask : t_full
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #5000000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    do_reset();
    t_idle();
    i_isr_host_model.load(2040);
    t_periods();
    t_full();
    print_verdict();
  end
endmodule : isr_replay_sim_tb
